// File: rsf_pkg.sv
// What this block does
// - Link runs 9600 baud, 8N1, both directions.
// - No flow control; no handshake lines used.
// - Received characters are never echoed back.
// - Reset always enters auto-detect mode.
// - Found tag reported as type prefix plus serial.
// - Report repeats while tag present, stops otherwise.
// - Any received character in auto mode enters command.
// - Entering command mode sends acknowledgement S.
// - Commands execute only in command mode.
// - Content is ASCII; bytes as two hex digits.
// - Command letters are case insensitive.
// - Commands need no CR LF terminator.
// - Every response ends with CR then LF.
// - Response letters upper case, except the prefix.
// - Mode-change command returns to auto, silently.
// - Power-save turns field off, answers P.
package rsf_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned BAUD = 9600;
   localparam int unsigned BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
   localparam int unsigned HALF_CYC = BIT_CYC / 2;
   localparam int unsigned DATA_BITS = 8;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_S = 8'h53;
   localparam logic [7:0] CH_P = 8'h50;
   localparam logic [7:0] CH_N = 8'h4E;
   localparam logic [7:0] CH_C = 8'h43;
   localparam logic [7:0] CH_U = 8'h55;
   localparam logic [7:0] CH_T = 8'h54;
   localparam logic [7:0] CH_H = 8'h48;
   localparam logic [7:0] CH_HL = 8'h68;
   localparam logic [7:0] CASE_MASK = 8'hDF;
   localparam int unsigned SERIAL_BYTES = 5;
   typedef enum logic [1:0] {RSF_TAG_RO, RSF_TAG_RW32, RSF_TAG_RW7,
      RSF_TAG_RW64} rsf_tag_t;
endpackage

// File: rsf_uart_rx.sv
`timescale 1ns/10ps
module rsf_uart_rx #(
   parameter int unsigned BIT_CYC = rsf_pkg::BIT_CYC // Clock cycles per bit.
) (
   input wire logic core_clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic rxd, // Serial line from the host.
   output logic rx_valid, // One-cycle pulse per good character.
   output logic [7:0] rx_data, // Received character.
   output logic rx_ferr // One-cycle pulse on a framing error.
);
   logic rxd_m_q, rxd_s_q;
   logic busy_q;
   logic armed_q;
   logic [15:0] cnt_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;

   // Two flops before anything looks at the pin.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxd_m_q <= 1'b1;
         rxd_s_q <= 1'b1;
      end else begin
         rxd_m_q <= rxd;
         rxd_s_q <= rxd_m_q;
      end
   end

   // Sample mid-bit: half a period after the start edge, then whole bits.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         armed_q <= 1'b0;
         cnt_q <= 16'h0000;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         rx_valid <= 1'b0;
         rx_ferr <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         rx_valid <= 1'b0;
         rx_ferr <= 1'b0;
         if (!busy_q) begin
            // A low stop bit must not be taken for the next start bit,
            // so the line has to be seen idle before a new frame starts.
            if (rxd_s_q) begin
               armed_q <= 1'b1;
            end else if (armed_q) begin
               armed_q <= 1'b0;
               busy_q <= 1'b1;
               cnt_q <= 16'(BIT_CYC / 2 - 1);
               bit_q <= 4'h0;
            end
         end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
         end else begin
            cnt_q <= 16'(BIT_CYC - 1);
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0) begin
               // A start bit gone high was a glitch.
               if (rxd_s_q) busy_q <= 1'b0;
            end else if (bit_q <= 4'(rsf_pkg::DATA_BITS)) begin
               sh_q <= {rxd_s_q, sh_q[7:1]};
            end else begin
               busy_q <= 1'b0;
               if (rxd_s_q) begin
                  rx_valid <= 1'b1;
                  rx_data <= sh_q;
               end else begin
                  rx_ferr <= 1'b1;
               end
            end
         end
      end
   end
endmodule // rsf_uart_rx

// File: rsf_uart_tx.sv
`timescale 1ns/10ps
module rsf_uart_tx #(
   parameter int unsigned BIT_CYC = rsf_pkg::BIT_CYC // Clock cycles per bit.
) (
   input wire logic core_clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic tx_valid, // Character offered.
   output logic tx_ready, // Transmitter idle, takes the character.
   input wire logic [7:0] tx_data, // Character to send.
   output logic txd // Serial line to the host.
);
   logic busy_q;
   logic [15:0] cnt_q;
   logic [3:0] bit_q;
   logic [9:0] sh_q;

   assign tx_ready = !busy_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         cnt_q <= 16'h0000;
         bit_q <= 4'h0;
         sh_q <= 10'h3FF;
         txd <= 1'b1;
      end else if (!busy_q) begin
         txd <= 1'b1;
         if (tx_valid) begin
            // Frame is start, eight data bits LSB first, one stop.
            busy_q <= 1'b1;
            sh_q <= {1'b1, tx_data, 1'b0};
            cnt_q <= 16'(BIT_CYC - 1);
            bit_q <= 4'h0;
            txd <= 1'b0;
         end
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end else begin
         cnt_q <= 16'(BIT_CYC - 1);
         bit_q <= bit_q + 4'h1;
         sh_q <= {1'b1, sh_q[9:1]};
         txd <= sh_q[1];
         if (bit_q == 4'h9) begin
            busy_q <= 1'b0;
            txd <= 1'b1;
         end
      end
   end
endmodule // rsf_uart_tx

// File: rsf_front_end.sv
`timescale 1ns/10ps
module rsf_front_end #(
   parameter int unsigned BIT_CYC = rsf_pkg::BIT_CYC // Clock cycles per bit.
) (
   input wire logic core_clk, // System clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic rxd, // Serial data from the host.
   output logic txd, // Serial data to the host.
   input wire logic tag_present, // Reader core sees a tag, level.
   input wire logic [1:0] tag_type, // Class of the present tag.
   input wire logic [39:0] tag_serial, // Serial number of the tag.
   output logic auto_mode, // High while in auto-detect mode.
   output logic field_on, // Radio field enable.
   output logic cmd_valid, // Other command letter for the core, pulse.
   output logic [7:0] cmd_char, // Upper-cased command letter.
   output logic rx_ferr // Framing error seen, pulse.
);
   typedef enum {RSF_AUTO, RSF_ACK, RSF_CMD, RSF_REPORT,
      RSF_PWR} rsf_mode_t;
   rsf_mode_t mode_q;
   logic rx_valid;
   logic [7:0] rx_data, up_char;
   logic tx_valid, tx_ready;
   logic [7:0] tx_data;
   // Two-entry buffer between the message builder and the transmitter.
   logic [7:0] buf_q [2];
   logic [1:0] cnt_q;
   logic wr_ptr_q, rd_ptr_q;
   logic src_valid, src_ready;
   logic [7:0] src_char;
   logic [3:0] idx_q, msg_len;
   logic [39:0] ser_q;
   logic [1:0] typ_q;
   // A character that arrives during a report waits here until the line ends.
   logic pend_q;

   rsf_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
      .core_clk(core_clk),
      .rst(rst),
      .rxd(rxd),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .rx_ferr(rx_ferr)
   );

   rsf_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
      .core_clk(core_clk),
      .rst(rst),
      .tx_valid(tx_valid),
      .tx_ready(tx_ready),
      .tx_data(tx_data),
      .txd(txd)
   );

   assign up_char = rx_data & rsf_pkg::CASE_MASK;

   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      // Upper-case digits only, so A-F never go out in lower case.
      hex_ch = (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
   endfunction

   // Report length: prefix, ten hex digits, CR, LF.
   localparam logic [3:0] REP_LEN = 4'(2 * rsf_pkg::SERIAL_BYTES + 3);

   always_comb begin
      src_char = rsf_pkg::CH_LF;
      msg_len = 4'h3;
      if (mode_q == RSF_REPORT) begin
         msg_len = REP_LEN;
         if (idx_q == 4'h0) begin
            unique case (typ_q)
               2'(rsf_pkg::RSF_TAG_RO): src_char = rsf_pkg::CH_U;
               2'(rsf_pkg::RSF_TAG_RW32): src_char = rsf_pkg::CH_T;
               2'(rsf_pkg::RSF_TAG_RW7): src_char = rsf_pkg::CH_H;
               default: src_char = rsf_pkg::CH_HL;
            endcase
         end else if (idx_q <= 4'(2 * rsf_pkg::SERIAL_BYTES)) begin
            // Two hex digits per byte, most significant nibble first.
            src_char = hex_ch(ser_q[39:36]);
         end else if (idx_q == REP_LEN - 4'h2) begin
            src_char = rsf_pkg::CH_CR;
         end
      end else begin
         if (idx_q == 4'h0) begin
            src_char = (mode_q == RSF_PWR) ? rsf_pkg::CH_P : rsf_pkg::CH_S;
         end else if (idx_q == 4'h1) begin
            src_char = rsf_pkg::CH_CR;
         end
      end
   end

   // Only the message builder feeds the buffer; received bytes never do.
   assign src_valid = (mode_q == RSF_ACK) || (mode_q == RSF_REPORT) ||
      (mode_q == RSF_PWR);
   assign src_ready = (cnt_q != 2'h2);
   assign tx_valid = (cnt_q != 2'h0);
   assign tx_data = buf_q[rd_ptr_q];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 2'h0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
      end else begin
         if (src_valid && src_ready) begin
            buf_q[wr_ptr_q] <= src_char;
            wr_ptr_q <= !wr_ptr_q;
         end
         if (tx_valid && tx_ready) rd_ptr_q <= !rd_ptr_q;
         cnt_q <= cnt_q + 2'(src_valid && src_ready) -
            2'(tx_valid && tx_ready);
      end
   end

   wire msg_done = src_valid && src_ready && (idx_q == msg_len - 4'h1);

   // Mode sequencing. No flow-control line exists; the host is never paced.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_q <= RSF_AUTO;
         idx_q <= 4'h0;
         ser_q <= 40'h0;
         typ_q <= 2'h0;
         pend_q <= 1'b0;
         field_on <= 1'b1;
         cmd_valid <= 1'b0;
         cmd_char <= 8'h00;
      end else begin
         cmd_valid <= 1'b0;
         if (src_valid && src_ready) begin
            idx_q <= idx_q + 4'h1;
            if (mode_q == RSF_REPORT && idx_q != 4'h0)
               ser_q <= {ser_q[35:0], 4'h0};
         end
         unique case (mode_q)
            RSF_AUTO: begin
               idx_q <= 4'h0;
               if (rx_valid) begin
                  // Any value switches mode and is never executed.
                  mode_q <= RSF_ACK;
               end else if (tag_present) begin
                  mode_q <= RSF_REPORT;
                  ser_q <= tag_serial;
                  typ_q <= tag_type;
               end
            end
            RSF_REPORT: begin
               // A report in flight finishes, so the host sees whole lines.
               if (rx_valid) pend_q <= 1'b1;
               if (msg_done) begin
                  idx_q <= 4'h0;
                  pend_q <= 1'b0;
                  mode_q <= (pend_q || rx_valid) ? RSF_ACK : RSF_AUTO;
               end
            end
            RSF_ACK, RSF_PWR: begin
               if (msg_done) begin
                  idx_q <= 4'h0;
                  mode_q <= RSF_CMD;
               end
            end
            RSF_CMD: begin
               idx_q <= 4'h0;
               // Each letter acts alone; no terminator is awaited.
               if (rx_valid) begin
                  field_on <= 1'b1;
                  if (up_char == rsf_pkg::CH_C) begin
                     mode_q <= RSF_AUTO;
                  end else if (up_char == rsf_pkg::CH_P) begin
                     field_on <= 1'b0;
                     mode_q <= RSF_PWR;
                  end else begin
                     cmd_valid <= 1'b1;
                     cmd_char <= up_char;
                  end
               end
            end
         endcase
      end
   end

   assign auto_mode = (mode_q == RSF_AUTO) || (mode_q == RSF_REPORT);

   chk_ferr_no_switch: assert property (@(posedge core_clk) disable iff (rst)
      rx_ferr && mode_q == RSF_AUTO |=> mode_q != RSF_ACK)
      else $error("framing error switched mode");
   chk_rx_to_ack: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && mode_q == RSF_AUTO |=> mode_q == RSF_ACK)
      else $error("character in auto mode did not switch");
   chk_ack_first: assert property (@(posedge core_clk) disable iff (rst)
      mode_q == RSF_ACK && idx_q == 4'h0 && src_ready |-> src_char == rsf_pkg::CH_S)
      else $error("acknowledge is not S");
   chk_cr_before_lf: assert property (@(posedge core_clk) disable iff (rst)
      src_valid && src_ready && src_char == rsf_pkg::CH_CR |=>
      src_char == rsf_pkg::CH_LF)
      else $error("CR not followed by LF");
   chk_no_cmd_auto: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && mode_q != RSF_CMD |=> !cmd_valid)
      else $error("command outside command mode");
   chk_c_to_auto: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && mode_q == RSF_CMD && up_char == rsf_pkg::CH_C |=>
      mode_q == RSF_AUTO && !src_valid)
      else $error("mode change failed or answered");
   chk_p_field_off: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && mode_q == RSF_CMD && up_char == rsf_pkg::CH_P |=>
      !field_on && src_char == rsf_pkg::CH_P)
      else $error("power save failed");
   chk_no_lower: assert property (@(posedge core_clk) disable iff (rst)
      src_valid && idx_q != 4'h0 |-> !(src_char >= 8'h61 && src_char <= 8'h7A))
      else $error("lower-case response letter");
   chk_buf_bound: assert property (@(posedge core_clk) disable iff (rst)
      cnt_q <= 2'h2)
      else $error("buffer overfilled");
   chk_ferr_no_cmd: assert property (@(posedge core_clk) disable iff (rst)
      rx_ferr |=> !cmd_valid)
      else $error("framing error gave a command");
   chk_field_restore: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && mode_q == RSF_CMD |=>
      field_on == (up_char != rsf_pkg::CH_P))
      else $error("field not restored by command");
   chk_cmd_upper: assert property (@(posedge core_clk) disable iff (rst)
      cmd_valid |-> !(cmd_char >= 8'h61 && cmd_char <= 8'h7A))
      else $error("command letter not upper case");
   chk_tag_report: assert property (@(posedge core_clk) disable iff (rst)
      mode_q == RSF_AUTO && tag_present && !rx_valid |=>
      mode_q == RSF_REPORT)
      else $error("present tag not reported");
   chk_no_tag_idle: assert property (@(posedge core_clk) disable iff (rst)
      mode_q == RSF_AUTO && !tag_present && !rx_valid |=>
      mode_q == RSF_AUTO)
      else $error("report without a tag");
   chk_pend_ack: assert property (@(posedge core_clk) disable iff (rst)
      mode_q == RSF_REPORT && msg_done && (pend_q || rx_valid) |=>
      mode_q == RSF_ACK)
      else $error("character during report lost");
endmodule // rsf_front_end

// File: rsf_host_model.sv
`timescale 1ns/10ps
module rsf_host_model #(
   parameter int BIT = rsf_pkg::BIT_CYC // Clock cycles per bit.
) (
   input wire logic core_clk, // System clock, used to time the bits.
   output logic rxd, // Line into the block.
   input wire logic txd // Line out of the block.
);
   logic [7:0] got_q[$];
   logic [7:0] sh;

   initial rxd = 1'b1;

   // A character goes out whole with no wait on anything.
   task automatic send(input logic [7:0] ch, input logic stop_bit);
      logic [9:0] fr;
      fr = {stop_bit, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk);
         rxd = fr[i];
         repeat (BIT - 1) @(negedge core_clk);
      end
      @(negedge core_clk);
      rxd = 1'b1;
   endtask

   // Samples mid-bit, LSB first; the host never pushes back.
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge core_clk);
         sh[i] = txd;
      end
      repeat (BIT) @(posedge core_clk);
      got_q.push_back(txd ? sh : 8'hFF);
   end
endmodule // rsf_host_model

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
   // A short bit time keeps the run small; the design default stays 9600.
   localparam int TB_BIT = 16;
   localparam int LIMIT = 40000;
   localparam int CH = 10 * TB_BIT;
   logic core_clk, rst, rxd, txd, tag_present, auto_mode, field_on;
   logic cmd_valid, rx_ferr;
   logic [1:0] tag_type;
   logic [39:0] tag_serial, exp_ser;
   logic [7:0] cmd_char, last_cmd, ch;
   logic [63:0] r;
   int err_count = 0, checks_done = 0, cyc = 0, n_cmd = 0, n_ferr = 0;
   int seed;

   rsf_front_end #(.BIT_CYC(TB_BIT)) u_rsf_front_end (
      .core_clk(core_clk), .rst(rst),
      .rxd(rxd), .txd(txd), .tag_present(tag_present),
      .tag_type(tag_type), .tag_serial(tag_serial),
      .auto_mode(auto_mode), .field_on(field_on), .cmd_valid(cmd_valid),
      .cmd_char(cmd_char), .rx_ferr(rx_ferr));
   rsf_host_model #(.BIT(TB_BIT)) u_rsf_host_model (
      .core_clk(core_clk), .rxd(rxd),
      .txd(txd));

   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cyc++;
      if (cmd_valid === 1'b1) begin
         n_cmd++;
         last_cmd = cmd_char;
      end
      if (rx_ferr === 1'b1) n_ferr++;
      if (cyc == LIMIT) begin
         err_count++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [39:0] seen,
      input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic expect_char(input logic [7:0] exp);
      int n;
      n = 0;
      while (u_rsf_host_model.got_q.size() == 0 && n < 2 * CH) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 2 * CH) check("tx char", 40'hFFFF, 40'(exp));
      else check("tx char", 40'(u_rsf_host_model.got_q.pop_front()),
         40'(exp));
   endtask

   // Two whole character times with nothing on the line.
   task automatic quiet();
      repeat (2 * CH) @(posedge core_clk);
      check("silent", 40'(u_rsf_host_model.got_q.size()), 40'h0);
   endtask

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   function automatic logic [7:0] pfx(input logic [1:0] t);
      case (t)
         2'h0: return 8'h55;
         2'h1: return 8'h54;
         2'h2: return 8'h48;
         default: return 8'h68;
      endcase
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      seed = 16;
      rst = 1'b1;
      tag_present = 1'b0;
      tag_type = 2'h0;
      tag_serial = 40'h0;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      check("auto after reset", 40'(auto_mode), 40'h1);
      check("field after reset", 40'(field_on), 40'h1);
      check("idle txd", 40'(txd), 40'h1);
      ch = 8'h61 + 8'({$random(seed)} % 26);
      u_rsf_host_model.send(ch, 1'b1);
      expect_char(rsf_pkg::CH_S);
      expect_char(rsf_pkg::CH_CR);
      expect_char(rsf_pkg::CH_LF);
      check("cmd mode", 40'(auto_mode), 40'h0);
      $display("test mode switch done");
      ch = 8'h72 + 8'({$random(seed)} % 8);
      u_rsf_host_model.send(ch, 1'b1);
      repeat (20) @(posedge core_clk);
      check("cmd count", 40'(n_cmd), 40'h1);
      check("cmd letter", 40'(last_cmd), 40'(ch & 8'hDF));
      u_rsf_host_model.send(8'h76, 1'b0);
      repeat (20) @(posedge core_clk);
      check("ferr count", 40'(n_ferr), 40'h1);
      check("no cmd on ferr", 40'(n_cmd), 40'h1);
      quiet();
      $display("test command letters done");
      u_rsf_host_model.send(8'h70, 1'b1);
      expect_char(rsf_pkg::CH_P);
      expect_char(rsf_pkg::CH_CR);
      expect_char(rsf_pkg::CH_LF);
      check("field off", 40'(field_on), 40'h0);
      u_rsf_host_model.send(8'h63, 1'b1);
      repeat (20) @(posedge core_clk);
      check("field back on", 40'(field_on), 40'h1);
      check("back to auto", 40'(auto_mode), 40'h1);
      check("no cmd for c p", 40'(n_cmd), 40'h1);
      quiet();
      $display("test power and mode change done");
      // Each report's digits are checked while the next one's serial is already set,
      // so a design that samples the serial late shows up as a wrong hex digit.
      @(negedge core_clk);
      r = {$random(seed), $random(seed)};
      tag_serial = r[39:0];
      tag_type = 2'h0;
      tag_present = 1'b1;
      for (int k = 0; k < 4; k++) begin
         exp_ser = tag_serial;
         expect_char(pfx(2'(k)));
         @(negedge core_clk);
         r = {$random(seed), $random(seed)};
         tag_serial = r[39:0];
         tag_type = 2'(k + 1);
         if (k == 3) u_rsf_host_model.send(8'h7A, 1'b1);
         for (int i = 9; i >= 0; i--) begin
            expect_char(hexc(exp_ser[4*i +: 4]));
         end
         expect_char(rsf_pkg::CH_CR);
         expect_char(rsf_pkg::CH_LF);
      end
      expect_char(rsf_pkg::CH_S);
      expect_char(rsf_pkg::CH_CR);
      expect_char(rsf_pkg::CH_LF);
      quiet();
      tag_present = 1'b0;
      $display("test tag reports done");
      close_out();
   end
endmodule // tb_top
